/* File: dv/board_model.sv */
// Acquisition board model driving the serial select lines
`timescale 1ns/1ps
module board_model (
  input wire clk,
  output reg sdi,
  output reg sck,
  output reg strobeN
);
  initial begin
    sdi = 1'b0;
    sck = 1'b1;
    strobeN = 1'b1;
  end
  task automatic half;
    repeat (4) @(negedge clk);
  endtask
  // Data settles a half period before the rising edge takes it
  task automatic shift(input [15:0] v, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      sdi = v[i];
      sck = 1'b0;
      half;
      sck = 1'b1;
      half;
    end
    // Released line must not keep showing the last bit
    sdi = ~sdi;
  endtask
  task automatic select(input [15:0] s);
    strobeN = 1'b0;
    half;
    shift(s, 16);
    strobeN = 1'b1;
    half;
  endtask
  task automatic deselect;
    strobeN = 1'b0;
    half;
  endtask
  task automatic write(input [15:0] s, input [15:0] v, input int n);
    select(s);
    shift(v, n);
    deselect;
  endtask
endmodule

/* File: dv/chassis_scan_list_controller_sva.sv */
// Port-level assertions for the chassis scan list controller
`timescale 1ns/1ps
module chassis_scan_list_controller_sva (
  input wire clk,
  input wire rst,
  input wire serial_shift_clock,
  input wire select_strobe_n,
  input wire trigger_clock_input,
  input wire [15:0] slotSelect,
  input wire [3:0] scanSlot,
  input wire [15:0] scan_control_line,
  input wire scanActive,
  input wire [7:0] listLevel
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_sel_onehot: assert property ($onehot0(slotSelect))
    else $error("slot select not one-hot");
  chk_sel_drop: assert property (!select_strobe_n [*5] |->
    slotSelect == 16'h0000) else $error("select kept while strobe low");
  chk_sel_hold: assert property (select_strobe_n [*6] |->
    $stable(slotSelect)) else $error("select moved while strobe high");
  chk_sel_rise: assert property ($changed(slotSelect) &&
    slotSelect != 16'h0000 |-> select_strobe_n) else $error("early select");
  chk_lines_idle: assert property (!scanActive |->
    scan_control_line == 16'hffff) else $error("scan line low when idle");
  chk_lines_slot: assert property (scan_control_line != 16'hffff |->
    scan_control_line == ~(16'h0001 << scanSlot)) else $error("wrong line");
  chk_head_hold: assert property ((!trigger_clock_input &&
    select_strobe_n && serial_shift_clock) [*8] |-> $stable(scanSlot) &&
    $stable(scanActive)) else $error("head moved without trigger");
  chk_level_step: assert property ((select_strobe_n &&
    !trigger_clock_input) [*8] ##1 $changed(listLevel) |->
    listLevel == $past(listLevel) + 8'h01) else $error("list level jump");
endmodule
bind chassis_scan_list_controller chassis_scan_list_controller_sva
  chassis_scan_list_controller_sva_inst (.clk(clk), .rst(rst),
  .serial_shift_clock(serial_shift_clock), .select_strobe_n(select_strobe_n),
  .trigger_clock_input(trigger_clock_input), .slotSelect(slotSelect),
  .scanSlot(scanSlot), .scan_control_line(scan_control_line),
  .scanActive(scanActive), .listLevel(listLevel));

/* File: dv/chassis_scan_list_controller_test.sv */
// Self-checking bench for the chassis scan list controller
`timescale 1ns/1ps
module chassis_scan_list_controller_test;
  logic clk, rst, trig;
  logic [31:0] r;
  logic [15:0] s;
  logic [15:0] ent [3];
  wire sdi, sck, strobeN, scanActive;
  wire [15:0] slotSelect, lines;
  wire [3:0] scanSlot;
  wire [7:0] listLevel;
  int fail_count = 0;
  int compares = 0;
  board_model board_model_inst (.clk(clk), .sdi(sdi), .sck(sck),
    .strobeN(strobeN));
  chassis_scan_list_controller chassis_scan_list_controller_inst (
    .clk(clk), .rst(rst), .serial_data_in(sdi), .serial_shift_clock(sck),
    .select_strobe_n(strobeN), .trigger_clock_input(trig),
    .slotSelect(slotSelect), .scanSlot(scanSlot), .scan_control_line(lines),
    .scanActive(scanActive), .listLevel(listLevel));
  function automatic [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic [15:0] expSel(input [15:0] v);
    expSel = (v[8:4] == 5'h00) ? 16'h0001 << v[3:0] : 16'h0000;
  endfunction
  function automatic [3:0] expSlot(input [15:0] e);
    expSlot = e[10:7] + 4'h1;
  endfunction
  task automatic check(input [15:0] got, input [15:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Each pulse is one sample; extra cycles let the synchroniser settle
  task automatic pulse(input int n);
    repeat (n) begin
      trig = 1'b1;
      wt(4);
      trig = 1'b0;
      wt(4);
    end
    wt(8);
  endtask
  task automatic tcw(input [7:0] v);
    board_model_inst.write(16'h000d, {8'h00, v}, 8);
    wt(8);
  endtask
  task automatic results;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (60000) @(posedge clk);
    fail_count++;
    results;
  end
  initial begin
    rst = 1'b1;
    trig = 1'b0;
    r = 32'hb5f671c6;
    wt(10);
    rst = 1'b0;
    wt(4);
    check(lines, 16'hffff);
    check(listLevel, 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = lfsr(r);
      s = {r[15:9], 4'h0, r[8], 1'b0, r[2:0]};
      board_model_inst.select(s);
      wt(8);
      check(slotSelect, expSel(s));
      board_model_inst.deselect;
      wt(8);
      check(slotSelect, 16'h0000);
    end
    $display("select test done");
    for (int i = 0; i < 3; i++) begin
      r = lfsr(r);
      ent[i] = {r[15:7], 5'h00, r[1:0]};
      board_model_inst.write(16'h000e, ent[i], 16);
      wt(8);
      check(listLevel, 16'(i + 1));
    end
    tcw(8'h7b);
    for (int i = 0; i < 3; i++) begin
      check(scanSlot, expSlot(ent[i]));
      check(lines, ~(16'h0001 << expSlot(ent[i])));
      pulse(ent[i][1:0] + 1);
    end
    check(scanActive, 1'b0);
    $display("scan test done");
    tcw(8'h6b);
    for (int i = 0; i < 4; i++) begin
      check(scanSlot, expSlot(ent[i % 3]));
      check(scanActive, 1'b1);
      pulse(ent[i % 3][1:0] + 1);
    end
    check(scanSlot, expSlot(ent[1]));
    $display("wrap test done");
    tcw(8'h3e);
    check(scanActive, 1'b1);
    check(scanSlot, expSlot(ent[0]));
    pulse(6);
    check(scanSlot, expSlot(ent[0]));
    tcw(8'h77);
    check(listLevel, 8'h00);
    check(lines, 16'hffff);
    $display("control test done");
    results;
  end
endmodule

/* File: hdl/chassis_scan_list_controller.v */
// Serial-loaded chassis scan list sequencer
`timescale 1ns/1ps
`include "scan_list_map.vh"

module chassis_scan_list_controller #(
  parameter SINGLE_CHASSIS = 0,
  parameter [4:0] CHASSIS_ID = 5'h00
) (
  input wire clk,
  input wire rst,
  input wire serial_data_in,
  input wire serial_shift_clock,
  input wire select_strobe_n,
  input wire trigger_clock_input,
  output reg [15:0] slotSelect,
  output reg [3:0] scanSlot,
  output reg [15:0] scan_control_line,
  output reg scanActive,
  output reg [7:0] listLevel
);

  // Each pin passes two flops before logic reads it; the third flop
  // only remembers the previous level so that edges can be found; on the data pin it goes unread
  reg [2:0] sdiSync;
  reg [2:0] sckSync;
  reg [2:0] strSync;
  reg [2:0] trgSync;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sdiSync <= 3'h0;
    end else begin
      sdiSync <= {sdiSync[1:0], serial_data_in};
    end
  end

  // Serial clock and strobe idle high; resetting to that level keeps a
  // false edge from appearing just after reset
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sckSync <= 3'h7;
    end else begin
      sckSync <= {sckSync[1:0], serial_shift_clock};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strSync <= 3'h7;
    end else begin
      strSync <= {strSync[1:0], select_strobe_n};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      trgSync <= 3'h0;
    end else begin
      trgSync <= {trgSync[1:0], trigger_clock_input};
    end
  end

  wire sdi = sdiSync[1];
  wire sckRise = sckSync[1] & ~sckSync[2];
  wire strobeHigh = strSync[1];
  wire strobeFall = ~strSync[1] & strSync[2];
  wire trgRise = trgSync[1] & ~trgSync[2];

  reg [`SEL_WIDTH-1:0] sel_q;
  reg [`TIMING_WIDTH-1:0] timing_q;
  reg [`ENTRY_WIDTH-1:0] entryShift_q;
  reg [4:0] entryBits_q;
  reg [`ENTRY_WIDTH-1:0] fifoMem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0] wrPtr_q;
  reg [`FIFO_AW-1:0] rdPtr_q;
  reg [`FIFO_AW:0] count_q;
  reg [6:0] samples_q;
  reg running_q;
  reg pause_q;
  reg timingSel_q;

  function [3:0] entrySlot;
    input [`ENTRY_WIDTH-1:0] e;
    begin
      entrySlot = e[`ENT_SLOT_HI:`ENT_SLOT_LO] + 4'h1;
    end
  endfunction

  function [6:0] entryCount;
    input [`ENTRY_WIDTH-1:0] e;
    begin
      entryCount = e[`ENT_CNT_HI:`ENT_CNT_LO];
    end
  endfunction

  wire [4:0] chassisNumber = sel_q[`SEL_CHS_HI:`SEL_CHS_LO];
  wire [3:0] slotNumber = sel_q[`SEL_SLOT_HI:`SEL_SLOT_LO];
  wire chassisHit = (SINGLE_CHASSIS != 0) ||
                    (chassisNumber == CHASSIS_ID);
  wire selActive = strobeHigh & chassisHit;
  wire timingSel = selActive & (slotNumber == `SLOT_TIMING);
  wire entrySel = selActive & (slotNumber == `SLOT_ENTRY);
  // Reset, rewind and load act only once the write is complete, at the strobe
  // fall; the read, once, scan and clock enable bits act as each bit shifts in
  wire timingDone = strobeFall & timingSel_q;
  wire doReset = timingDone & ~timing_q[`TC_RESET];
  wire doRewind = timingDone & ~timing_q[`TC_REWIND];
  wire doLoad = timingDone & ~timing_q[`TC_LOAD];

  wire [`ENTRY_WIDTH-1:0] headEntry = fifoMem[rdPtr_q];
  wire [`ENTRY_WIDTH-1:0] newEntry = {entryShift_q[14:0], sdi};
  wire listEmpty = (count_q == 9'h000);
  wire listFull = (count_q == 9'h100);
  wire lastEntry = (rdPtr_q + 8'h01 == wrPtr_q);
  wire [`FIFO_AW-1:0] nextPtr =
    lastEntry ? 8'h00 : rdPtr_q + 8'h01;
  // A full list drops the write rather than overwriting the head
  wire appendNow = sckRise & entrySel & (entryBits_q == 5'd15) & ~listFull;
  wire readOn = timing_q[`TC_READ];
  wire clkOn = timing_q[`TC_TRIGGER_CLOCK_ENABLE];
  wire sample = trgRise & clkOn & running_q & readOn & ~listEmpty;
  // The trigger that finds the count used up advances instead of
  // counting; the cycle after an advance takes no sample
  wire step = sample & ~pause_q & ~timingDone;
  wire advance = step & (samples_q == 7'h00);
  wire countDown = step & (samples_q != 7'h00);
  wire scanLive = running_q & readOn & ~listEmpty;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_q <= 16'h0000;
    end else if (sckRise && !strobeHigh) begin
      sel_q <= {sel_q[14:0], sdi};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timing_q <= `TC_RESET_VAL;
    end else if (sckRise && timingSel) begin
      timing_q <= {timing_q[6:0], sdi};
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      timingSel_q <= 1'b0;
    end else begin
      timingSel_q <= timingSel;
    end
  end

  // A part-written entry is thrown away when the strobe falls
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      entryShift_q <= 16'h0000;
      entryBits_q <= 5'h00;
    end else if (strobeFall) begin
      entryBits_q <= 5'h00;
    end else if (sckRise && entrySel) begin
      entryShift_q <= {entryShift_q[14:0], sdi};
      entryBits_q <= (entryBits_q == 5'd16) ? 5'd1 : entryBits_q + 5'd1;
    end
  end

  // Storage has no reset: the pointers alone say which words are valid
  always @(posedge clk) begin
    if (appendNow) begin
      fifoMem[wrPtr_q] <= newEntry;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wrPtr_q <= 8'h00;
    end else if (doReset) begin
      wrPtr_q <= 8'h00;
    end else if (appendNow) begin
      wrPtr_q <= wrPtr_q + 8'h01;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= 9'h000;
    end else if (doReset) begin
      count_q <= 9'h000;
    end else if (doRewind) begin
      count_q <= {1'b0, wrPtr_q};
    end else if (appendNow) begin
      count_q <= count_q + 9'h001;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdPtr_q <= 8'h00;
    end else if (doReset || doRewind) begin
      rdPtr_q <= 8'h00;
    end else if (advance) begin
      rdPtr_q <= nextPtr;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      samples_q <= 7'h00;
    end else if (doReset) begin
      samples_q <= 7'h00;
    end else if (doRewind) begin
      samples_q <= entryCount(fifoMem[0]);
    end else if (doLoad) begin
      samples_q <= entryCount(headEntry);
    end else if (advance) begin
      samples_q <= entryCount(fifoMem[nextPtr]);
    end else if (countDown) begin
      samples_q <= samples_q - 7'h01;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      running_q <= 1'b0;
    end else if (doReset) begin
      running_q <= 1'b0;
    end else if (doRewind || doLoad) begin
      running_q <= 1'b1;
    end else if (advance && lastEntry && timing_q[`TC_ONCE]) begin
      running_q <= 1'b0;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pause_q <= 1'b0;
    end else begin
      pause_q <= advance;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      slotSelect <= 16'h0000;
    end else begin
      slotSelect <= 16'h0000;
      if (selActive) begin
        slotSelect[slotNumber] <= 1'b1;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scanSlot <= 4'h0;
    end else begin
      scanSlot <= entrySlot(headEntry);
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scanActive <= 1'b0;
    end else begin
      scanActive <= scanLive;
    end
  end

  // Lines are active low and follow a live scan only, so a paused list
  // never leaves a slot driven
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scan_control_line <= 16'hffff;
    end else begin
      scan_control_line <= 16'hffff;
      if (timing_q[`TC_SCANEN] && scanLive) begin
        scan_control_line[entrySlot(headEntry)] <= 1'b0;
      end
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      listLevel <= 8'h00;
    end else begin
      listLevel <= count_q[7:0];
    end
  end

endmodule

/* File: hdl/scan_list_map.vh */
// Field positions, widths and reset values of the scan list controller
`ifndef SCAN_LIST_MAP_VH
`define SCAN_LIST_MAP_VH
`define SEL_WIDTH 16
`define SEL_CHS_HI 8
`define SEL_CHS_LO 4
`define SEL_SLOT_HI 3
`define SEL_SLOT_LO 0
`define TIMING_WIDTH 8
`define ENTRY_WIDTH 16
`define SLOT_TIMING 4'hd
`define SLOT_ENTRY 4'he
`define TC_REWIND 3'd6
`define TC_READ 3'd5
`define TC_ONCE 3'd4
`define TC_RESET 3'd3
`define TC_LOAD 3'd2
`define TC_SCANEN 3'd1
`define TC_TRIGGER_CLOCK_ENABLE 3'd0
`define TC_RESET_VAL 8'h4c
`define ENT_SLOT_HI 10
`define ENT_SLOT_LO 7
`define ENT_CNT_HI 6
`define ENT_CNT_LO 0
`define FIFO_DEPTH 256
`define FIFO_AW 8
`endif
